// ---- dcg_gate.v ----
`timescale 1ns/1ps
`include "dcg_regs.vh"
module dcg_gate #(
   parameter BIT_CYCLES = `DCG_BIT_CYCLES
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // debug serial pin, open drain
   input  wire        debug_serial_pin_in,
   output reg         debug_serial_pin_out,
   output reg         debug_serial_pin_oe,
   // option and device state
   input  wire        read_protect_option,
   input  wire [7:0]  status_value,
   input  wire [7:0]  regfile_rdata,
   // register file side
   output reg  [11:0] regfile_addr,
   output reg  [7:0]  regfile_wdata,
   output reg         regfile_we,
   // dispatch
   output reg  [7:0]  exec_cmd,
   output reg         exec_strobe,
   output reg         debug_mode_bit
);
   // ---------------------------------------------------------------
   // state codes
   // ---------------------------------------------------------------
   localparam S_CMD   = 3'd0; // wait command byte
   localparam S_ADRH  = 3'd1; // register address high
   localparam S_ADRL  = 3'd2; // register address low
   localparam S_SIZE  = 3'd3; // byte count
   localparam S_WDATA = 3'd4; // write data bytes
   localparam S_RDATA = 3'd5; // read data bytes out
   localparam S_CTL   = 3'd6; // control byte
   localparam S_TX    = 3'd7; // advance address after each data byte
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // commands that run outside debug mode
   function allowed_idle;
      input [7:0] c;
      begin
         allowed_idle = (c == `DCG_CMD_RD_REV) || (c == `DCG_CMD_RD_STAT) ||
                        (c == `DCG_CMD_WR_CTL) || (c == `DCG_CMD_RD_CTL);
      end
   endfunction
   // commands blocked by the protect option
   function blocked_rp;
      input [7:0] c;
      begin
         blocked_rp = (c == `DCG_CMD_WR_PC)   || (c == `DCG_CMD_RD_PC)   ||
                      (c == `DCG_CMD_WR_PMEM) || (c == `DCG_CMD_RD_PMEM) ||
                      (c == `DCG_CMD_WR_DMEM) || (c == `DCG_CMD_RD_DMEM) ||
                      (c == `DCG_CMD_STEP)    || (c == `DCG_CMD_STUFF)   ||
                      (c == `DCG_CMD_EXEC);
      end
   endfunction
   // upper page test, used for both reads and writes
   // the whole peripheral page counts, every address from F00 to FFF
   function in_page;
      input [11:0] a;
      begin
         in_page = (a[11:8] == `DCG_PAGE_HI);
      end
   endfunction
   // ---------------------------------------------------------------
   // serial framer
   // ---------------------------------------------------------------
   wire [7:0] rx_data;   // received byte
   wire       rx_valid;  // one cycle per byte
   wire       tx_busy;   // frame in flight
   wire       line_oe;   // framer drives low
   reg  [7:0] tx_data;   // byte to send
   reg        tx_start;  // send pulse
   dcg_serial #(.BIT_CYCLES(BIT_CYCLES)) u_ser (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .line_in  (debug_serial_pin_in),
      .line_oe  (line_oe),
      .rx_data  (rx_data),
      .rx_valid (rx_valid),
      .tx_data  (tx_data),
      .tx_start (tx_start),
      .tx_busy  (tx_busy)
   );
   // ---------------------------------------------------------------
   // command engine
   // ---------------------------------------------------------------
   reg [2:0]  state;     // engine state
   reg [7:0]  cmd;       // latched command
   reg [8:0]  count;     // bytes left, 256 when size is zero
   reg        wait_tx;   // reply in flight, hold off next byte
   reg [7:0]  ctl;       // control register image
   wire       refuse_rd; // read refused by mode or protection
   assign refuse_rd = !debug_mode_bit || (read_protect_option && !in_page(regfile_addr));
   // main sequencer; pin out fixed low, only enable toggles
   always @(posedge clk_sys) begin
      tx_start    <= 1'b0;
      regfile_we  <= 1'b0;
      exec_strobe <= 1'b0;
      debug_serial_pin_out <= 1'b0;
      debug_serial_pin_oe  <= line_oe;
      if (!resetn) begin
         state <= S_CMD;
         cmd <= 8'h00;
         count <= 9'h000;
         wait_tx <= 1'b0;
         ctl <= `DCG_CTL_RESET;
         debug_mode_bit <= 1'b0;
         tx_data <= 8'h00;
         regfile_addr <= 12'h000;
         regfile_wdata <= 8'h00;
         exec_cmd <= 8'h00;
         debug_serial_pin_oe <= 1'b0;
      end else if (wait_tx) begin
         // wait for framer to pick up and finish the reply
         if (!tx_start && !tx_busy)
            wait_tx <= 1'b0;
      end else begin
         case (state)
            S_CMD: if (rx_valid) begin
               cmd <= rx_data;
               if (!debug_mode_bit && !allowed_idle(rx_data)) begin
                  // register commands still consume their bytes
                  if (rx_data == `DCG_CMD_WR_REG || rx_data == `DCG_CMD_RD_REG)
                     state <= S_ADRH;
                  // others refused outright
               end else if (read_protect_option && blocked_rp(rx_data)) begin
                  state <= S_CMD; // disabled
               end else begin
                  case (rx_data)
                     `DCG_CMD_RD_REV: begin
                        tx_data <= `DCG_REV_VALUE; tx_start <= 1'b1; wait_tx <= 1'b1;
                     end
                     `DCG_CMD_RD_STAT: begin
                        tx_data <= status_value; tx_start <= 1'b1; wait_tx <= 1'b1;
                     end
                     `DCG_CMD_RD_CTL: begin
                        // mode bit shown live: under protection a written
                        // zero is not taken, so the image alone would lie
                        tx_data <= {debug_mode_bit, ctl[6:0]};
                        tx_start <= 1'b1;
                        wait_tx <= 1'b1;
                     end
                     `DCG_CMD_WR_CTL: state <= S_CTL;
                     `DCG_CMD_WR_REG, `DCG_CMD_RD_REG: state <= S_ADRH;
                     `DCG_CMD_RSVD: state <= S_CMD; // silent
                     default: begin
                        if (rx_data <= `DCG_CMD_EXEC) begin
                           exec_cmd <= rx_data; // handed on
                           exec_strobe <= 1'b1;
                        end
                        // codes above the table are no-ops
                     end
                  endcase
               end
            end
            S_CTL: if (rx_valid) begin
               ctl <= rx_data;
               // under protection the mode bit is sticky until reset
               if (read_protect_option)
                  debug_mode_bit <= debug_mode_bit | rx_data[`DCG_CTL_MODE_BIT];
               else
                  debug_mode_bit <= rx_data[`DCG_CTL_MODE_BIT];
               state <= S_CMD;
            end
            S_ADRH: if (rx_valid) begin
               regfile_addr[11:8] <= rx_data[3:0];
               state <= S_ADRL;
            end
            S_ADRL: if (rx_valid) begin
               regfile_addr[7:0] <= rx_data;
               state <= S_SIZE;
            end
            S_SIZE: if (rx_valid) begin
               count <= (rx_data == 8'h00) ? 9'h100 : {1'b0, rx_data};
               state <= (cmd == `DCG_CMD_RD_REG) ? S_RDATA : S_WDATA;
            end
            S_WDATA: if (rx_valid) begin
               regfile_wdata <= rx_data;
               // outside debug, or under protection off page or bad flash value: drop
               if (debug_mode_bit && (!read_protect_option ||
                   (in_page(regfile_addr) && (regfile_addr != `DCG_FCTL_ADDR ||
                    rx_data == `DCG_FCTL_MASS))))
                  regfile_we <= 1'b1;
               count <= count - 9'h001;
               state <= S_TX;
            end
            S_RDATA: begin
               // refused reads still send the full count as all ones
               tx_data <= refuse_rd ? `DCG_REFUSED_BYTE : regfile_rdata;
               tx_start <= 1'b1;
               wait_tx <= 1'b1;
               count <= count - 9'h001;
               state <= S_TX;
            end
            S_TX: begin
               // advance address after each data byte
               regfile_addr <= regfile_addr + 12'h001;
               if (count == 9'h000)
                  state <= S_CMD;
               else
                  state <= (cmd == `DCG_CMD_RD_REG) ? S_RDATA : S_WDATA;
            end
            default: state <= S_CMD;
         endcase
      end
   end
endmodule

// ---- dcg_gate_assertions.sv ----
`timescale 1ns/1ps
`include "dcg_regs.vh"
module dcg_gate_assertions (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        resetn,
   // serial pin
   input wire logic        debug_serial_pin_in,
   input wire logic        debug_serial_pin_out,
   input wire logic        debug_serial_pin_oe,
   // option and device state
   input wire logic        read_protect_option,
   input wire logic [7:0]  status_value,
   input wire logic [7:0]  regfile_rdata,
   // register file and dispatch
   input wire logic [11:0] regfile_addr,
   input wire logic [7:0]  regfile_wdata,
   input wire logic        regfile_we,
   input wire logic [7:0]  exec_cmd,
   input wire logic        exec_strobe,
   input wire logic        debug_mode_bit
);
   // ---------------------------------------------------------------
   // one clock domain, so clock and disable are given once
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // reset itself is checked, so this one is never disabled
   AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn
      |=> !debug_mode_bit && !exec_strobe && !regfile_we && !debug_serial_pin_oe)
      else $error("outputs active after reset");
   AST_PIN_OPEN_DRAIN: assert property (debug_serial_pin_out == 1'b0)
      else $error("pin driven high");
   AST_STROBE_IN_DEBUG: assert property (exec_strobe |-> debug_mode_bit)
      else $error("command run outside debug mode");
   AST_STROBE_PROTECT: assert property (exec_strobe && read_protect_option
      |-> !(exec_cmd inside {8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11,
                             8'h12}))
      else $error("protected command run");
   AST_MODE_KEEP: assert property (read_protect_option && $past(read_protect_option)
      |-> !$fell(debug_mode_bit)) else $error("mode cleared while protected");
   AST_WE_IN_DEBUG: assert property (regfile_we
      |-> debug_mode_bit && $past(debug_mode_bit)) else $error("write outside debug mode");
   AST_WE_PAGE: assert property (regfile_we && read_protect_option
      |-> regfile_addr[11:8] == 4'hF) else $error("protected write below upper page");
   AST_WE_FLASH: assert property (regfile_we && read_protect_option
      && regfile_addr == `DCG_FCTL_ADDR |-> regfile_wdata == `DCG_FCTL_MASS)
      else $error("flash control written with other than mass erase");
endmodule
bind dcg_gate dcg_gate_assertions i_dcg_gate_assertions (
   .clk_sys(clk_sys), .resetn(resetn), .debug_serial_pin_in(debug_serial_pin_in),
   .debug_serial_pin_out(debug_serial_pin_out), .debug_serial_pin_oe(debug_serial_pin_oe),
   .read_protect_option(read_protect_option), .status_value(status_value),
   .regfile_rdata(regfile_rdata), .regfile_addr(regfile_addr), .regfile_wdata(regfile_wdata),
   .regfile_we(regfile_we), .exec_cmd(exec_cmd), .exec_strobe(exec_strobe),
   .debug_mode_bit(debug_mode_bit));

// ---- dcg_host.sv ----
`timescale 1ns/1ps
module dcg_host #(
   parameter BIT_CYCLES = 4
) (
   // clock and resolved line
   input  wire       clk_sys,
   input  wire       line,
   // host pull-down and received bytes
   output reg        host_oe,
   output reg  [7:0] rx_byte,
   output reg        rx_valid
);
   reg     [7:0] shift;  // bits gathered from the device
   integer       i;      // receive bit index
   initial begin
      host_oe = 1'b0;
      rx_byte = 8'h00;
      rx_valid = 1'b0;
   end
   // ---------------------------------------------------------------
   // send one frame; caller enters just after a falling edge
   // ---------------------------------------------------------------
   task send_byte(input [7:0] b);
      integer k;
      begin
         host_oe = 1'b1;  // start bit pulls low
         repeat (BIT_CYCLES) @(negedge clk_sys);
         for (k = 0; k < 8; k = k + 1) begin  // lsb first
            host_oe = ~b[k];
            repeat (BIT_CYCLES) @(negedge clk_sys);
         end
         host_oe = 1'b0;  // stop bit: released to the pull-up
         repeat (BIT_CYCLES) @(negedge clk_sys);
      end
   endtask
   // receive device frames; only a low that the host is not making counts
   always @(posedge clk_sys) begin
      if (line === 1'b0 && !host_oe) begin
         repeat (BIT_CYCLES / 2) @(posedge clk_sys);
         for (i = 0; i < 8; i = i + 1) begin  // lsb first
            repeat (BIT_CYCLES) @(posedge clk_sys);
            shift[i] = line;
         end
         repeat (BIT_CYCLES) @(posedge clk_sys);
         rx_byte <= shift;
         rx_valid <= line;  // a low stop bit drops the byte
         @(posedge clk_sys);
         rx_valid <= 1'b0;
      end
   end
endmodule

// ---- dcg_regs.vh ----
`ifndef DCG_REGS_VH
`define DCG_REGS_VH
// command codes
`define DCG_CMD_RD_REV     8'h00
`define DCG_CMD_WR_CNTR    8'h01
`define DCG_CMD_RD_STAT    8'h02
`define DCG_CMD_RD_CNTR    8'h03
`define DCG_CMD_WR_CTL     8'h04
`define DCG_CMD_RD_CTL     8'h05
`define DCG_CMD_WR_PC      8'h06
`define DCG_CMD_RD_PC      8'h07
`define DCG_CMD_WR_REG     8'h08
`define DCG_CMD_RD_REG     8'h09
`define DCG_CMD_WR_PMEM    8'h0A
`define DCG_CMD_RD_PMEM    8'h0B
`define DCG_CMD_WR_DMEM    8'h0C
`define DCG_CMD_RD_DMEM    8'h0D
`define DCG_CMD_RD_CRC     8'h0E
`define DCG_CMD_RSVD       8'h0F
`define DCG_CMD_STEP       8'h10
`define DCG_CMD_STUFF      8'h11
`define DCG_CMD_EXEC       8'h12
// revision byte returned by the read revision command; value is arbitrary
`define DCG_REV_VALUE      8'h01
// control register field
`define DCG_CTL_MODE_BIT   7
`define DCG_CTL_RESET      8'h00
// protected register page and flash control
`define DCG_PAGE_HI        4'hF
`define DCG_PAGE_MID       4'hF
`define DCG_FCTL_ADDR      12'hFF8
`define DCG_FCTL_MASS      8'h63
`define DCG_REFUSED_BYTE   8'hFF
// serial framing
`define DCG_DATA_BITS      8
`define DCG_BIT_CYCLES     16'h0032
`endif

// ---- dcg_serial.v ----
`timescale 1ns/1ps
`include "dcg_regs.vh"
// ---------------------------------------------------------------
// byte framer: start, eight data bits lsb first, stop
// ---------------------------------------------------------------
module dcg_serial #(
   parameter BIT_CYCLES = 16'd50
) (
   // clock and reset
   input  wire       clk_sys,
   input  wire       resetn,
   // line
   input  wire       line_in,
   output reg        line_oe,
   // receive side
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   // transmit side
   input  wire [7:0] tx_data,
   input  wire       tx_start,
   output reg        tx_busy
);
   reg [15:0] rx_cnt;   // cycles left in current rx bit
   reg [3:0]  rx_bit;   // rx bit index, 0 idle
   reg [7:0]  rx_sh;    // rx shift register
   reg [15:0] tx_cnt;   // cycles left in current tx bit
   reg [3:0]  tx_bit;   // tx bit index
   reg [9:0]  tx_sh;    // frame: stop, data, start
   // bit time cut to the counter width on purpose
   localparam [15:0] BIT_LEN   = BIT_CYCLES[15:0];
   // start is seen one edge late, so the first wait is one short of 1.5 bits
   localparam [15:0] FIRST_MID = BIT_LEN + (BIT_LEN >> 1) - 16'h0001;
   // receiver; samples mid-bit, start found on falling line
   // held off while our own frame is out: the pin enable lags the framer by
   // one cycle, so the line can still be low after line_oe has dropped
   always @(posedge clk_sys) begin
      rx_valid <= 1'b0;
      if (!resetn) begin
         rx_cnt <= 16'h0000;
         rx_bit <= 4'h0;
         rx_sh  <= 8'h00;
         rx_data <= 8'h00;
      end else if (rx_bit == 4'h0) begin
         if (!line_in && !tx_busy) begin
            rx_bit <= 4'h1;
            rx_cnt <= FIRST_MID; // middle of d0
         end
      end else if (rx_cnt != 16'h0000) begin
         rx_cnt <= rx_cnt - 16'h0001;
      end else if (rx_bit == 4'h9) begin
         // stop bit: a low stop is a framing fault, byte dropped
         rx_bit <= 4'h0;
         if (line_in) begin
            rx_data  <= rx_sh;
            rx_valid <= 1'b1;
         end
      end else begin
         rx_sh  <= {line_in, rx_sh[7:1]}; // lsb first
         rx_bit <= rx_bit + 4'h1;
         rx_cnt <= BIT_LEN - 16'h0001;
      end
   end
   // transmitter; open drain, so only lows are driven
   always @(posedge clk_sys) begin
      if (!resetn) begin
         tx_cnt  <= 16'h0000;
         tx_bit  <= 4'h0;
         tx_sh   <= 10'h3FF;
         tx_busy <= 1'b0;
         line_oe <= 1'b0;
      end else if (!tx_busy) begin
         if (tx_start) begin
            tx_sh   <= {1'b1, tx_data, 1'b0};
            tx_busy <= 1'b1;
            tx_bit  <= 4'h0;
            tx_cnt  <= BIT_LEN - 16'h0001;
            line_oe <= 1'b1;
         end
      end else if (tx_cnt != 16'h0000) begin
         tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit == 4'h9) begin
         tx_busy <= 1'b0;
         line_oe <= 1'b0;
      end else begin
         tx_bit  <= tx_bit + 4'h1;
         tx_cnt  <= BIT_LEN - 16'h0001;
         line_oe <= ~tx_sh[tx_bit + 4'h1];
      end
   end
endmodule

// ---- debug_command_gating_test.sv ----
`timescale 1ns/1ps
`include "dcg_regs.vh"
module debug_command_gating_test;
   localparam BIT_CYCLES = 4;  // shortened bit time keeps the run brief
   reg         clk_sys = 1'b0;
   reg         resetn = 1'b0;
   reg         read_protect_option = 1'b0;
   reg  [7:0]  status_value = 8'h00;
   reg  [7:0]  regfile_rdata = 8'h00;
   wire        line;
   wire        host_oe;
   wire        dut_out;
   wire        dut_oe;
   wire [11:0] regfile_addr;
   wire [7:0]  regfile_wdata;
   wire        regfile_we;
   wire [7:0]  exec_cmd;
   wire        exec_strobe;
   wire        debug_mode_bit;
   wire [7:0]  rx_byte;
   wire        rx_valid;
   integer     seed = 43088;
   integer     errors = 0;
   integer     comparisons = 0;
   integer     cycles = 0;
   reg  [31:0] r;           // random draw
   reg  [23:0] notes[$];    // expected events, oldest first
   always #10 clk_sys = ~clk_sys;
   // open-drain line with pull-up: low while either party pulls
   assign line = ~((dut_oe === 1'b1) | host_oe);
   dcg_gate #(.BIT_CYCLES(BIT_CYCLES)) i_dcg_gate (.clk_sys(clk_sys), .resetn(resetn),
      .debug_serial_pin_in(line), .debug_serial_pin_out(dut_out),
      .debug_serial_pin_oe(dut_oe), .read_protect_option(read_protect_option),
      .status_value(status_value), .regfile_rdata(regfile_rdata),
      .regfile_addr(regfile_addr), .regfile_wdata(regfile_wdata), .regfile_we(regfile_we),
      .exec_cmd(exec_cmd), .exec_strobe(exec_strobe), .debug_mode_bit(debug_mode_bit));
   dcg_host #(.BIT_CYCLES(BIT_CYCLES)) i_dcg_host (.clk_sys(clk_sys), .line(line),
      .host_oe(host_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));
   // ---------------------------------------------------------------
   // comparison, event matching and closing
   // ---------------------------------------------------------------
   task check(input [23:0] seen, input [23:0] expected);
      begin
         comparisons = comparisons + 1;
         if (seen !== expected) begin
            errors = errors + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, expected);
         end
      end
   endtask
   task take(input [23:0] seen);
      begin
         if (notes.size() == 0) check(seen, 24'hxx_xxxx);  // unasked event
         else check(seen, notes.pop_front());
      end
   endtask
   task summarize;
      begin
         $display("counts: comparisons %0d errors %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // watcher: kind 1 reply byte, 2 dispatch, 3 register write
   always @(posedge clk_sys) begin
      if (exec_strobe === 1'b1) take({4'h2, 12'h000, exec_cmd});
      if (regfile_we === 1'b1) take({4'h3, regfile_addr, regfile_wdata});
      if (rx_valid === 1'b1) take({4'h1, 12'h000, rx_byte});
      cycles = cycles + 1;
      if (cycles == 30000) begin  // hang guard
         errors = errors + 1;
         $display("unexpected at %0t: timeout", $time);
         summarize;
      end
   end
   // wait for every noted event, then long enough for a stray frame
   task settle;
      integer n;
      begin
         n = 0;
         while (notes.size() != 0 && n < 400) begin
            @(negedge clk_sys);
            n = n + 1;
         end
         if (notes.size() != 0) check(24'h00_0000, notes.pop_front());
         repeat (12 * BIT_CYCLES) @(negedge clk_sys);
      end
   endtask
   task cmd1(input [7:0] c);
      begin
         i_dcg_host.send_byte(c);
         settle;
      end
   endtask
   // register command with one data byte: address high, low, size 1
   task reg_cmd(input [7:0] c, input [11:0] a, input [7:0] d);
      begin
         i_dcg_host.send_byte(c);
         i_dcg_host.send_byte({4'h0, a[11:8]});
         i_dcg_host.send_byte(a[7:0]);
         i_dcg_host.send_byte(8'h01);
         if (c == `DCG_CMD_WR_REG) i_dcg_host.send_byte(d);
         settle;
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      r = $random(seed);
      status_value = r[7:0];
      regfile_rdata = r[15:8];
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      check({23'h00_0000, debug_mode_bit}, 24'h00_0000);
      notes.push_back({4'h1, 12'h000, status_value});
      cmd1(`DCG_CMD_RD_STAT);
      notes.push_back({4'h1, 12'h000, `DCG_REV_VALUE});
      cmd1(`DCG_CMD_RD_REV);
      cmd1(`DCG_CMD_STEP);  // refused outside debug
      notes.push_back({4'h1, 12'h000, `DCG_REFUSED_BYTE});
      reg_cmd(`DCG_CMD_RD_REG, r[27:16], 8'h00);
      reg_cmd(`DCG_CMD_WR_REG, 12'h012, r[31:24]);  // dropped
      i_dcg_host.send_byte(`DCG_CMD_WR_CTL);
      cmd1(8'h80);
      check({23'h00_0000, debug_mode_bit}, 24'h00_0001);
      $display("test outside debug done");
      notes.push_back({4'h2, 12'h000, `DCG_CMD_STEP});
      cmd1(`DCG_CMD_STEP);
      cmd1(`DCG_CMD_RSVD);  // silent
      cmd1({3'b111, r[4:0]});  // reserved high code, silent
      notes.push_back({4'h3, 12'h345, r[7:0]});
      reg_cmd(`DCG_CMD_WR_REG, 12'h345, r[7:0]);
      notes.push_back({4'h1, 12'h000, regfile_rdata});
      reg_cmd(`DCG_CMD_RD_REG, 12'h345, 8'h00);
      $display("test debug open done");
      read_protect_option = 1'b1;
      i_dcg_host.send_byte(`DCG_CMD_WR_CTL);
      cmd1(8'h00);
      check({23'h00_0000, debug_mode_bit}, 24'h00_0001);
      notes.push_back({4'h1, 12'h000, 8'h80});  // mode bit still reads set
      cmd1(`DCG_CMD_RD_CTL);
      cmd1(`DCG_CMD_STEP);
      reg_cmd(`DCG_CMD_WR_REG, 12'h3A5, r[7:0]);
      notes.push_back({4'h3, 12'hF13, r[7:0]});
      reg_cmd(`DCG_CMD_WR_REG, 12'hF13, r[7:0]);
      reg_cmd(`DCG_CMD_WR_REG, `DCG_FCTL_ADDR, 8'h55);
      notes.push_back({4'h3, `DCG_FCTL_ADDR, `DCG_FCTL_MASS});
      reg_cmd(`DCG_CMD_WR_REG, `DCG_FCTL_ADDR, `DCG_FCTL_MASS);
      notes.push_back({4'h1, 12'h000, `DCG_REFUSED_BYTE});
      reg_cmd(`DCG_CMD_RD_REG, 12'h3A5, 8'h00);
      notes.push_back({4'h1, 12'h000, regfile_rdata});
      reg_cmd(`DCG_CMD_RD_REG, 12'hF21, 8'h00);
      resetn = 1'b0;
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      check({23'h00_0000, debug_mode_bit}, 24'h00_0000);
      $display("test protected done");
      summarize;
   end
endmodule
